// >>> bench/boot_link_properties.sv
// Checker for the host-to-device boot link, watching the interface signals.
// Assumes back-to-back host bytes and that no payload repeats a framing pattern.
`timescale 1ns/100ps
module boot_link_properties
  import boot_link_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] h2d_byte_in,
  input wire logic h2d_valid_in,
  input wire logic [7:0] d2h_byte_in,
  input wire logic d2h_valid_in
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_hb(logic [7:0] b);
    h2d_valid_in && h2d_byte_in == b;
  endsequence
  sequence s_short(logic [7:0] c);
    s_hb(LEN_SHORT) ##1 s_hb(c) ##1 s_hb(c);
  endsequence

  // Answer is visible three cycles after the last packet byte: check, answer, launch
  property p_nonzero;
    d2h_valid_in |-> d2h_byte_in != ZERO_BYTE;
  endproperty
  a_nonzero: assert property (p_nonzero) else $error("zero answer byte");
  property p_ping;
    s_short(CMD_PING) |-> ##3 (d2h_valid_in && d2h_byte_in == ACK_BYTE) ##1 !d2h_valid_in;
  endproperty
  a_ping: assert property (p_ping) else $error("ping answer wrong");
  property p_query;
    s_short(cmd_query_result) |-> ##3 (d2h_valid_in && d2h_byte_in == ACK_BYTE)
      ##1 (d2h_valid_in && d2h_byte_in == LEN_SHORT) ##1 d2h_valid_in ##1 d2h_valid_in;
  endproperty
  a_query: assert property (p_query) else $error("status reply broken");
  property p_reply_sum;
    s_short(cmd_query_result) |-> ##6 d2h_byte_in == $past(d2h_byte_in);
  endproperty
  a_reply_sum: assert property (p_reply_sum) else $error("reply sum wrong");
  property p_host_ack;
    s_short(cmd_query_result) |-> ##8 s_hb(ACK_BYTE);
  endproperty
  a_host_ack: assert property (p_host_ack) else $error("reply not acked");
  property p_reset;
    s_short(CMD_RESET) |-> ##3 d2h_valid_in && d2h_byte_in == ACK_BYTE;
  endproperty
  a_reset: assert property (p_reset) else $error("reset not acked");
  property p_run;
    s_hb(LEN_RUN) ##1 h2d_valid_in ##1 s_hb(CMD_RUN) ##1 h2d_valid_in [*4]
      |-> ##3 d2h_valid_in && d2h_byte_in == ACK_BYTE;
  endproperty
  a_run: assert property (p_run) else $error("run not acked");
  property p_erase_late;
    s_hb(LEN_DOWNLOAD) ##1 h2d_valid_in ##1 s_hb(CMD_DOWNLOAD) ##1 h2d_valid_in [*8]
      |=> !d2h_valid_in [*3];
  endproperty
  a_erase_late: assert property (p_erase_late) else $error("early answer");
endmodule : boot_link_properties

// >>> bench/serial_boot_loader_protocol_tb.sv
// Testbench: host and device joined by one link, plus a device driven raw.
// Flash side answers requests after a short fixed delay.
`timescale 1ns/100ps
module serial_boot_loader_protocol_tb
  import boot_link_pkg::*;
;
  typedef logic [7:0] bq_t[$];
  logic sys_clk = 1'b0, arst_n = 1'b0, rq = 1'b0;
  logic [7:0] rl = 8'h00, st_a, hst, pd_a;
  payload_t rp = '0;
  logic er_a, er_b, pr_a, pr_b, run_a, sr_a, busy, done, acked, sv;
  logic [31:0] ea_a, es_a, pa_a, pad_a, pad_b, ra_a;
  logic [3:0] esr_a = 4'h0, esr_b = 4'h0;
  logic [1:0] psr_a = 2'h0, psr_b = 2'h0;
  logic run_seen = 1'b0, sr_seen = 1'b0;
  int n_prog_a = 0, n_prog_b = 0, n_mismatch = 0, checks = 0;
  boot_link_if link();
  boot_link_if link_b();

  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    esr_a <= {esr_a[2:0], er_a};
    esr_b <= {esr_b[2:0], er_b};
    psr_a <= {psr_a[0], pr_a};
    psr_b <= {psr_b[0], pr_b};
    if (pr_a) begin
      n_prog_a <= n_prog_a + 1;
      pad_a <= pa_a;
    end
    if (pr_b) n_prog_b <= n_prog_b + 1;
    if (run_a) run_seen <= 1'b1;
    if (sr_a) sr_seen <= 1'b1;
  end

  boot_device i_boot_device (.sys_clk_in(sys_clk), .arst_n_in(arst_n), .link(link),
    .erase_req_out(er_a), .erase_addr_out(ea_a), .erase_size_out(es_a),
    .erase_done_in(esr_a[3]), .prog_req_out(pr_a), .prog_addr_out(pa_a), .prog_data_out(pd_a),
    .prog_done_in(psr_a[1]), .run_out(run_a), .run_addr_out(ra_a),
    .soft_reset_out(sr_a), .status_out(st_a));
  boot_device i_boot_device_b (.sys_clk_in(sys_clk), .arst_n_in(arst_n), .link(link_b),
    .erase_req_out(er_b), .erase_addr_out(), .erase_size_out(), .erase_done_in(esr_b[3]),
    .prog_req_out(pr_b), .prog_addr_out(pad_b), .prog_data_out(), .prog_done_in(psr_b[1]),
    .run_out(), .run_addr_out(), .soft_reset_out(), .status_out());
  boot_host #(.GAP_CYCLES(0)) i_boot_host (.sys_clk_in(sys_clk), .arst_n_in(arst_n),
    .link(link), .req_valid_in(rq), .req_len_in(rl), .req_payload_in(rp),
    .busy_out(busy), .done_out(done), .acked_out(acked), .status_valid_out(sv),
    .status_out(hst));
  boot_link_properties i_boot_link_properties (.sys_clk_in(sys_clk), .arst_n_in(arst_n),
    .h2d_byte_in(link.h2d_byte), .h2d_valid_in(link.h2d_valid),
    .d2h_byte_in(link.d2h_byte), .d2h_valid_in(link.d2h_valid));

  task tick;
    @(posedge sys_clk);
    #10;
  endtask : tick
  task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic hcmd(input logic [7:0] len, input payload_t p);
    int i;
    for (i = 0; i < 20 && busy !== 1'b0; i++) tick;
    rl = len;
    rp = p;
    rq = 1'b1;
    tick;
    rq = 1'b0;
    for (i = 0; i < 300 && done !== 1'b1; i++) tick;
    chk(done, 1'b1, "host done");
  endtask : hcmd
  task rb(input logic [7:0] b);
    link_b.h2d_byte = b;
    link_b.h2d_valid = 1'b1;
    tick;
  endtask : rb
  task idle;
    // Released byte lines flip so a stale value is never mistaken for data
    link_b.h2d_byte = ~link_b.h2d_byte;
    link_b.h2d_valid = 1'b0;
    tick;
  endtask : idle
  task rd(input logic [7:0] e);
    chk({link_b.d2h_valid, link_b.d2h_byte}, {1'b1, e}, "device byte");
  endtask : rd
  task automatic wans(input logic [7:0] e);
    int i;
    for (i = 0; i < 100 && link_b.d2h_valid !== 1'b1; i++) tick;
    rd(e);
  endtask : wans
  task qry(input logic [7:0] e);
    rb(8'h03);
    rb(cmd_query_result);
    rb(cmd_query_result);
    idle;
    wans(ACK_BYTE);
    tick;
    rd(LEN_SHORT);
    tick;
    rd(e);
    tick;
    rd(e);
    rb(ACK_BYTE);
    idle;
    tick;
  endtask : qry
  task rpkt(input bq_t p, input logic [7:0] e);
    foreach (p[i]) rb(p[i]);
    idle;
    wans(e);
    repeat (2) tick;
  endtask : rpkt

  task t_host_cmds;
    chk(st_a, STATUS_SUCCESS, "status after reset");
    hcmd(LEN_SHORT, payload_t'(72'h20));
    chk(acked, 1'b1, "ping");
    hcmd(LEN_SHORT, payload_t'(72'h23));
    chk({sv, hst}, {1'b1, STATUS_SUCCESS}, "query");
    hcmd(LEN_DOWNLOAD, payload_t'(72'h03_00_00_00_00_10_00_00_21));
    chk({es_a, ea_a}, {32'h3, 32'h1000}, "erase region");
    hcmd(LEN_SHORT, payload_t'(72'h23));
    chk({sv, hst}, {1'b1, STATUS_SUCCESS}, "download status");
    hcmd(8'h06, payload_t'(72'h33_22_11_24));
    chk({pad_a, 24'h0, pd_a}, {32'h1002, 32'h33}, "program");
    chk(n_prog_a, 3, "program count");
    hcmd(LEN_RUN, payload_t'(72'h78_56_34_12_22));
    chk({run_seen, ra_a}, {1'b1, 32'h12345678}, "run");
    hcmd(LEN_SHORT, payload_t'(72'h25));
    chk({acked, sr_seen}, 2'b11, "reset");
  endtask : t_host_cmds
  task t_gap_pad;
    rb(8'h00);
    rb(8'h03);
    idle;
    rb(8'h20);
    idle;
    idle;
    rb(8'h20);
    idle;
    wans(ACK_BYTE);
    repeat (2) tick;
  endtask : t_gap_pad
  task t_bad;
    rpkt('{8'h03, 8'h21, 8'h20}, NAK_BYTE);
    rpkt('{8'h01}, NAK_BYTE);
  endtask : t_bad
  task t_unknown;
    rpkt('{8'h03, 8'h30, 8'h30}, ACK_BYTE);
    qry(STATUS_UNKNOWN_CMD);
    // Wrong-length ping is framed fine, so it is acknowledged yet flagged
    rpkt('{8'h04, 8'h20, 8'h20, 8'h00}, ACK_BYTE);
    qry(STATUS_INVALID);
  endtask : t_unknown
  task t_data;
    rpkt('{8'h0b, 8'h43, 8'h21, 8'h0, 8'h0, 8'h20, 8'h0, 8'h0, 8'h0, 8'h0, 8'h02}, ACK_BYTE);
    rpkt('{8'h05, 8'h00, 8'h24, 8'hff, 8'hff}, NAK_BYTE);
    chk(n_prog_b, 0, "nak programmed");
    rpkt('{8'h05, 8'h22, 8'h24, 8'hff, 8'hff}, ACK_BYTE);
    chk(pad_b, 32'h2002, "address after resend");
    rpkt('{8'h04, 8'h25, 8'h24, 8'h01}, ACK_BYTE);
    chk(n_prog_b, 2, "beyond count");
    qry(STATUS_OVERRUN);
  endtask : t_data

  task summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    summarize;
  end
  initial begin
    link_b.h2d_byte = 8'h00;
    link_b.h2d_valid = 1'b0;
    repeat (12) @(posedge sys_clk);
    #10 arst_n = 1'b1;
    t_host_cmds;
    t_gap_pad;
    t_bad;
    t_unknown;
    t_data;
    summarize;
  end
endmodule : serial_boot_loader_protocol_tb

// >>> design/boot_device.sv
// Boot device end: receives framed packets, answers ACK/NAK, runs commands
// against the flash through request/done handshakes.
// Assumes the host end of boot_link_if on the same clock; flash side logic
// answers every erase or program request with a done pulse.
`timescale 1ns/100ps
// What this block does
// - First byte is total packet length
// - Second byte sums payload bytes only
// - Accept bytes with gaps or back-to-back
// - Host discards zeros before device answer
// - Answer 0xCC intact, 0x33 failed
// - ACK reflects reception, not command validity
// - Reply bytes contiguous after optional zeros
// - Host acknowledges every device packet
// - Host reissues command after its NAK
// - Zero bytes ignored before a response
// - First payload byte is command code
// - Ping sets status to success; a wrong-length ping sets it invalid
// - Status query returns one-byte status packet
// - Host should query status after commands
// - Download packet: address, count, MSB first
// - Erase whole region before answering download
// - Data commands program at advancing address
// - Host sends at most eight data bytes
// - Stop programming after full byte count
// - NAKed data leaves address unchanged
// - Run: ACK and start at address on the same cycle
// - Reset: ACK and software reset on the same cycle
module boot_device
  import boot_link_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  boot_link_if.device link,
  output logic erase_req_out,
  output logic [31:0] erase_addr_out,
  output logic [31:0] erase_size_out,
  input wire logic erase_done_in,
  output logic prog_req_out,
  output logic [31:0] prog_addr_out,
  output logic [7:0] prog_data_out,
  input wire logic prog_done_in,
  output logic run_out,
  output logic [31:0] run_addr_out,
  output logic soft_reset_out,
  output logic [7:0] status_out
);
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_SUM = 9'h002,
    S_PAY = 9'h004,
    S_CHECK = 9'h008,
    S_ERASE = 9'h010,
    S_PROG = 9'h020,
    S_ANSWER = 9'h040,
    S_REPLY = 9'h080,
    S_HOST_ACK = 9'h100
  } dev_state_t;

  typedef struct packed {
    dev_state_t state;
    logic [7:0] len;
    logic [7:0] cnt;
    logic [7:0] sum_rx;
    logic [7:0] sum_acc;
    payload_t pay;
    logic [7:0] answer;
    logic [7:0] status;
    logic [31:0] addr;
    logic [31:0] remain;
    logic [7:0] pidx;
    logic pwait;
    logic [1:0] ridx;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic erase_req;
    logic [31:0] erase_addr;
    logic [31:0] erase_size;
    logic prog_req;
    logic [7:0] prog_data;
    logic run;
    logic [31:0] run_addr;
    logic soft_reset;
  } dev_regs_t;

  dev_regs_t q;
  dev_regs_t d;
  logic [7:0] rx;
  logic rx_nz;
  logic [7:0] pay_cnt;

  assign rx = link.h2d_byte;
  assign rx_nz = link.h2d_valid && (rx != ZERO_BYTE);
  assign pay_cnt = q.len - LEN_HEADER;

  always_comb begin
    d = q;
    d.tx_valid = 1'b0;
    d.erase_req = 1'b0;
    d.prog_req = 1'b0;
    d.run = 1'b0;
    d.soft_reset = 1'b0;
    case (q.state)
      S_IDLE: begin
        // Zero fill between packets is skipped
        if (rx_nz) begin
          d.len = rx;
          d.cnt = 8'h00;
          d.sum_acc = 8'h00;
          if (rx < LEN_HEADER) begin
            d.answer = NAK_BYTE;
            d.state = S_ANSWER;
          end else begin
            d.state = S_SUM;
          end
        end
      end
      S_SUM: begin
        // Waits as long as needed for each byte
        if (link.h2d_valid) begin
          d.sum_rx = rx;
          d.state = (pay_cnt == 8'h00) ? S_CHECK : S_PAY;
        end
      end
      S_PAY: begin
        if (link.h2d_valid) begin
          // Bytes past the ninth of an oversized packet are drained but not stored
          if (q.cnt < MAX_PAY_B) begin
            d.pay[q.cnt[3:0]] = rx;
          end
          d.sum_acc = q.sum_acc + rx;
          d.cnt = q.cnt + 8'h01;
          if (q.cnt + 8'h01 == pay_cnt) begin
            d.state = S_CHECK;
          end
        end
      end
      S_CHECK: begin
        d.state = S_ANSWER;
        d.answer = ACK_BYTE;
        // Answer depends on framing only
        if (q.sum_acc != q.sum_rx || q.len < LEN_MIN || pay_cnt > MAX_PAY_B) begin
          d.answer = NAK_BYTE;
        end else begin
          case (q.pay[0])
            CMD_PING: begin
              d.status = (q.len == LEN_SHORT) ? STATUS_SUCCESS : STATUS_INVALID;
            end
            cmd_query_result: begin
              if (q.len != LEN_SHORT) begin
                d.status = STATUS_INVALID;
              end
            end
            CMD_DOWNLOAD: begin
              if (q.len == LEN_DOWNLOAD) begin
                d.addr = {q.pay[1], q.pay[2], q.pay[3], q.pay[4]};
                d.remain = {q.pay[5], q.pay[6], q.pay[7], q.pay[8]};
                d.erase_addr = d.addr;
                d.erase_size = d.remain;
                d.erase_req = 1'b1;
                d.state = S_ERASE;
              end else begin
                d.status = STATUS_INVALID;
              end
            end
            CMD_SEND_DATA: begin
              d.pidx = 8'h01;
              d.pwait = 1'b0;
              d.state = S_PROG;
            end
            CMD_RUN: begin
              if (q.len == LEN_RUN) begin
                d.run_addr = {q.pay[1], q.pay[2], q.pay[3], q.pay[4]};
                d.status = STATUS_SUCCESS;
              end else begin
                d.status = STATUS_INVALID;
              end
            end
            CMD_RESET: begin
              d.status = (q.len == LEN_SHORT) ? STATUS_SUCCESS : STATUS_INVALID;
            end
            default: begin
              d.status = STATUS_UNKNOWN_CMD;
            end
          endcase
        end
      end
      S_ERASE: begin
        // The answer is held back until the region is erased
        if (erase_done_in) begin
          d.status = STATUS_SUCCESS;
          d.state = S_ANSWER;
        end
      end
      S_PROG: begin
        if (q.pwait) begin
          if (prog_done_in) begin
            d.pwait = 1'b0;
            d.addr = q.addr + 32'h1;
            d.remain = q.remain - 32'h1;
            d.pidx = q.pidx + 8'h01;
          end
        end else if (q.pidx == pay_cnt) begin
          d.status = STATUS_SUCCESS;
          d.state = S_ANSWER;
        end else if (q.remain == 32'h0) begin
          // Bytes beyond the announced count are dropped
          d.status = STATUS_OVERRUN;
          d.state = S_ANSWER;
        end else begin
          d.prog_req = 1'b1;
          d.prog_data = q.pay[q.pidx[3:0]];
          d.pwait = 1'b1;
        end
      end
      S_ANSWER: begin
        d.tx_byte = q.answer;
        d.tx_valid = 1'b1;
        d.state = S_IDLE;
        // A NAKed packet never reached programming, so addr is kept
        if (q.answer == ACK_BYTE && q.len == LEN_SHORT && q.pay[0] == cmd_query_result) begin
          d.ridx = 2'd0;
          d.state = S_REPLY;
        end
        if (q.answer == ACK_BYTE && q.len == LEN_RUN && q.pay[0] == CMD_RUN) begin
          d.run = 1'b1;
        end
        if (q.answer == ACK_BYTE && q.len == LEN_SHORT && q.pay[0] == CMD_RESET) begin
          d.soft_reset = 1'b1;
        end
      end
      S_REPLY: begin
        // Length, sum, status on three back-to-back cycles
        d.tx_valid = 1'b1;
        d.ridx = q.ridx + 2'd1;
        d.tx_byte = (q.ridx == 2'd0) ? LEN_SHORT : q.status;
        if (q.ridx == 2'd2) begin
          d.state = S_HOST_ACK;
        end
      end
      S_HOST_ACK: begin
        // Any non-zero byte closes the reply; a NAK is followed by a re-query
        if (rx_nz) begin
          d.state = S_IDLE;
        end
      end
      default: begin
        d.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= '0;
      q.state <= S_IDLE;
      q.status <= STATUS_SUCCESS;
      q.answer <= NAK_BYTE;
    end else begin
      q <= d;
    end
  end

  assign link.d2h_byte = q.tx_byte;
  assign link.d2h_valid = q.tx_valid;
  assign erase_req_out = q.erase_req;
  assign erase_addr_out = q.erase_addr;
  assign erase_size_out = q.erase_size;
  assign prog_req_out = q.prog_req;
  assign prog_addr_out = q.addr;
  assign prog_data_out = q.prog_data;
  assign run_out = q.run;
  assign run_addr_out = q.run_addr;
  assign soft_reset_out = q.soft_reset;
  assign status_out = q.status;
endmodule : boot_device

// >>> design/boot_host.sv
// Boot host end: frames a user packet, sends it with a chosen byte gap,
// waits for the device answer and reads back status replies.
// Assumes the device end of boot_link_if on the same clock.
`timescale 1ns/100ps
module boot_host
  import boot_link_pkg::*;
#(
  parameter int GAP_CYCLES = 0
)
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  boot_link_if.host link,
  input wire logic req_valid_in,
  input wire logic [7:0] req_len_in,
  input wire payload_t req_payload_in,
  output logic busy_out,
  output logic done_out,
  output logic acked_out,
  output logic status_valid_out,
  output logic [7:0] status_out
);
  typedef enum logic [7:0] {
    H_IDLE = 8'h01,
    H_SEND = 8'h02,
    H_GAP = 8'h04,
    H_WAIT = 8'h08,
    H_RLEN = 8'h10,
    H_RSUM = 8'h20,
    H_RDATA = 8'h40,
    H_RESP = 8'h80
  } host_state_t;

  typedef struct packed {
    host_state_t state;
    logic [7:0] len;
    payload_t pay;
    logic [7:0] sum;
    logic [7:0] idx;
    logic [15:0] gap;
    logic [7:0] rlen;
    logic [7:0] rsum;
    logic [7:0] rdata;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic busy;
    logic done;
    logic acked;
    logic status_valid;
    logic [7:0] status;
  } host_regs_t;

  localparam logic [15:0] GAP_LOAD = 16'(GAP_CYCLES);

  host_regs_t q;
  host_regs_t d;
  logic [7:0] rx;
  logic rx_nz;
  logic [7:0] req_sum;

  assign rx = link.d2h_byte;
  assign rx_nz = link.d2h_valid && (rx != ZERO_BYTE);

  always_comb begin
    req_sum = 8'h00;
    for (int i = 0; i < MAX_PAY; i++) begin
      if (8'(i) < req_len_in - LEN_HEADER) begin
        req_sum = req_sum + req_payload_in[i];
      end
    end
  end

  always_comb begin
    d = q;
    d.tx_valid = 1'b0;
    d.done = 1'b0;
    d.status_valid = 1'b0;
    case (q.state)
      H_IDLE: begin
        if (req_valid_in) begin
          d.len = req_len_in;
          d.pay = req_payload_in;
          d.sum = req_sum;
          d.idx = 8'h00;
          d.busy = 1'b1;
          d.state = H_SEND;
        end
      end
      H_SEND: begin
        d.tx_valid = 1'b1;
        if (q.idx == 8'h00) begin
          d.tx_byte = q.len;
        end else if (q.idx == 8'h01) begin
          d.tx_byte = q.sum;
        end else begin
          d.tx_byte = q.pay[4'(q.idx - LEN_HEADER)];
        end
        d.idx = q.idx + 8'h01;
        d.gap = GAP_LOAD;
        if (q.idx + 8'h01 == q.len) begin
          d.state = H_WAIT;
        end else if (GAP_LOAD != 16'h0) begin
          d.state = H_GAP;
        end
      end
      H_GAP: begin
        d.gap = q.gap - 16'h1;
        if (q.gap == 16'h1) begin
          d.state = H_SEND;
        end
      end
      H_WAIT: begin
        // Zero bytes before the answer are discarded
        if (rx_nz) begin
          d.acked = (rx == ACK_BYTE);
          if (rx == ACK_BYTE && q.len == LEN_SHORT && q.pay[0] == cmd_query_result) begin
            d.state = H_RLEN;
          end else begin
            d.done = 1'b1;
            d.busy = 1'b0;
            d.state = H_IDLE;
          end
        end
      end
      H_RLEN: begin
        if (rx_nz) begin
          d.rlen = rx;
          d.state = H_RSUM;
        end
      end
      H_RSUM: begin
        if (link.d2h_valid) begin
          d.rsum = rx;
          d.state = H_RDATA;
        end
      end
      H_RDATA: begin
        if (link.d2h_valid) begin
          d.rdata = rx;
          d.state = H_RESP;
        end
      end
      H_RESP: begin
        d.tx_valid = 1'b1;
        if (q.rlen == LEN_SHORT && q.rsum == q.rdata) begin
          d.tx_byte = ACK_BYTE;
          d.status = q.rdata;
          d.status_valid = 1'b1;
          d.done = 1'b1;
          d.busy = 1'b0;
          d.state = H_IDLE;
        end else begin
          d.tx_byte = NAK_BYTE;
          d.idx = 8'h00;
          d.state = H_SEND;
        end
      end
      default: begin
        d.state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= '0;
      q.state <= H_IDLE;
    end else begin
      q <= d;
    end
  end

  assign link.h2d_byte = q.tx_byte;
  assign link.h2d_valid = q.tx_valid;
  assign busy_out = q.busy;
  assign done_out = q.done;
  assign acked_out = q.acked;
  assign status_valid_out = q.status_valid;
  assign status_out = q.status;
endmodule : boot_host

// >>> design/boot_link_if.sv
// Byte link between the boot host and the boot device.
// Each direction is a one-cycle byte strobe on the shared clock; no stall.
`timescale 1ns/100ps
interface boot_link_if;
  logic [7:0] h2d_byte;
  logic h2d_valid;
  logic [7:0] d2h_byte;
  logic d2h_valid;
  modport device (input h2d_byte, input h2d_valid, output d2h_byte, output d2h_valid);
  modport host (output h2d_byte, output h2d_valid, input d2h_byte, input d2h_valid);
endinterface : boot_link_if

// >>> design/boot_link_pkg.sv
// Shared constants for the serial boot link: framing, answer codes,
// command codes, packet lengths and status codes.
// Assumes both ends run on the same system clock.
package boot_link_pkg;
  localparam logic [7:0] ACK_BYTE = 8'hcc;
  localparam logic [7:0] NAK_BYTE = 8'h33;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  localparam logic [7:0] CMD_PING = 8'h20;
  localparam logic [7:0] CMD_DOWNLOAD = 8'h21;
  localparam logic [7:0] CMD_RUN = 8'h22;
  localparam logic [7:0] cmd_query_result = 8'h23;
  localparam logic [7:0] CMD_SEND_DATA = 8'h24;
  localparam logic [7:0] CMD_RESET = 8'h25;

  localparam logic [7:0] LEN_SHORT = 8'h03;
  localparam logic [7:0] LEN_RUN = 8'h07;
  localparam logic [7:0] LEN_DOWNLOAD = 8'h0b;
  localparam logic [7:0] LEN_HEADER = 8'h02;
  localparam logic [7:0] LEN_MIN = 8'h03;
  localparam int MAX_PAY = 9;
  localparam logic [7:0] MAX_PAY_B = 8'h09;

  // Status code values are arbitrary
  localparam logic [7:0] STATUS_SUCCESS = 8'h40;
  localparam logic [7:0] STATUS_UNKNOWN_CMD = 8'h41;
  localparam logic [7:0] STATUS_INVALID = 8'h42;
  localparam logic [7:0] STATUS_OVERRUN = 8'h43;

  typedef logic [MAX_PAY-1:0][7:0] payload_t;
endpackage : boot_link_pkg
